// ===== design/ivc_cmd_exec.sv
// Executes rotate-positive and indexed user variable commands.
`timescale 1ns/100ps
`include "ivc_consts.svh"
module ivc_cmd_exec (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  input wire logic prog_valid_in,
  input ivc_pkg::ivc_cmd_s prog_cmd_in,
  input wire logic [31:0] x_reg_in,
  input wire logic acc_load_in,
  input wire logic [31:0] acc_load_val_in,
  output logic [31:0] acc_out,
  output logic reply_valid_out,
  output ivc_pkg::ivc_reply_s reply_out,
  output logic axis_wr_out,
  output ivc_pkg::ivc_axis_s axis_out,
  output logic frame_bad_out
);
  typedef enum logic [1:0] {IVC_IDLE, IVC_VEL_MODE, IVC_VEL_PARAM} ivc_state_e;

  logic host_valid;
  ivc_pkg::ivc_cmd_s host_cmd;
  logic cmd_valid;
  ivc_pkg::ivc_cmd_s cmd;
  logic idx_ok;
  logic [7:0] idx;
  logic [31:0] user_var_q [`IVC_VAR_DEPTH];
  logic [31:0] acc_q;
  ivc_state_e state_q;
  logic [31:0] vel_q;

  ivc_frame_rx u_rx (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .byte_valid_in(byte_valid_in),
    .byte_in(byte_in),
    .frame_valid_out(host_valid),
    .frame_bad_out(frame_bad_out),
    .frame_out(host_cmd)
  );

  // Host frames win over a program command arriving in the same cycle; the
  // program sequencer must hold its command while a host frame is taken.
  assign cmd_valid = host_valid | prog_valid_in;
  assign cmd = host_valid ? host_cmd : prog_cmd_in;
  // X is signed: negative or above 255 fails the check.
  assign idx_ok = ($signed(x_reg_in) >= 0) && (x_reg_in <= `IVC_IDX_MAX);
  assign idx = x_reg_in[7:0];

  // User variable array, written by the two store commands.
  always_ff @(posedge clock_in) begin
    if (ce_in && cmd_valid && idx_ok) begin
      if (cmd.opcode == `IVC_OP_SET_IDX) begin
        user_var_q[idx] <= cmd.value;
      end else if (cmd.opcode == `IVC_OP_ACC_IDX) begin
        user_var_q[idx] <= acc_q;
      end
    end
  end

  // Accumulator: indexed load, else external load from the calculator path.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc_q <= `IVC_ACC_RESET;
    end else if (ce_in) begin
      if (cmd_valid && idx_ok && cmd.opcode == `IVC_OP_GET_IDX) begin
        acc_q <= user_var_q[idx];
      end else if (acc_load_in) begin
        acc_q <= acc_load_val_in;
      end
    end
  end
  assign acc_out = acc_q;

  // Rotate-positive: two axis writes, velocity mode then target velocity.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= IVC_IDLE;
      vel_q <= 32'h0;
      axis_wr_out <= 1'b0;
      axis_out <= '0;
    end else if (ce_in) begin
      axis_wr_out <= 1'b0;
      case (state_q)
        IVC_IDLE: begin
          // Only the opcode is decoded; other fields are don't care.
          if (cmd_valid && cmd.opcode == `IVC_OP_ROT_POS) begin
            vel_q <= acc_q;
            state_q <= IVC_VEL_MODE;
          end
        end
        IVC_VEL_MODE: begin
          axis_wr_out <= 1'b1;
          axis_out <= '{vel_mode: 1'b1, param: `IVC_PARAM_MODE_SEL, value: 32'h0};
          state_q <= IVC_VEL_PARAM;
        end
        IVC_VEL_PARAM: begin
          axis_wr_out <= 1'b1;
          // Positive velocity value means the counting-up direction.
          axis_out <= '{vel_mode: 1'b1, param: `IVC_PARAM_TGT_VEL, value: vel_q};
          state_q <= IVC_IDLE;
        end
        default: state_q <= IVC_IDLE;
      endcase
    end
  end

  // Replies go only to the host; ignored indexed commands still answer OK.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reply_valid_out <= 1'b0;
      reply_out <= '0;
    end else if (ce_in) begin
      reply_valid_out <= 1'b0;
      if (host_valid && (host_cmd.opcode == `IVC_OP_ROT_POS ||
          host_cmd.opcode == `IVC_OP_SET_IDX || host_cmd.opcode == `IVC_OP_GET_IDX ||
          host_cmd.opcode == `IVC_OP_ACC_IDX)) begin
        reply_valid_out <= 1'b1;
        reply_out <= '{status: `IVC_STATUS_OK, opcode: host_cmd.opcode, value: 32'h0};
      end
    end
  end

  // The mode step must reach the axis one enabled cycle after the sequence starts.
  a_rot_seq: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (ce_in && state_q == IVC_IDLE && cmd_valid && cmd.opcode == `IVC_OP_ROT_POS) ##1 ce_in
    |=> axis_wr_out && axis_out.param == `IVC_PARAM_MODE_SEL)
    else $error("velocity mode not selected first");

  a_vel_param: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (axis_wr_out && axis_out.param == `IVC_PARAM_MODE_SEL && ce_in) |=> axis_wr_out &&
    axis_out.param == `IVC_PARAM_TGT_VEL && axis_out.value == $past(vel_q))
    else $error("target velocity not written");

  // A target velocity write is only legal right behind an axis write with vel_mode set.
  a_mode_first: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (axis_wr_out && axis_out.param == `IVC_PARAM_TGT_VEL) |->
    $past(axis_wr_out) && $past(axis_out.vel_mode))
    else $error("target velocity written without mode select");

  a_rot_acc: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (ce_in && state_q == IVC_IDLE && cmd_valid && cmd.opcode == `IVC_OP_ROT_POS)
    |=> vel_q == $past(acc_q))
    else $error("velocity not taken from accumulator");

  // A second rotate during the two-cycle sequence must not disturb the latched speed.
  a_rot_busy: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state_q != IVC_IDLE) |=> $stable(vel_q))
    else $error("latched velocity changed during sequence");

  a_get_idx: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (ce_in && cmd_valid && idx_ok && cmd.opcode == `IVC_OP_GET_IDX)
    |=> acc_q == $past(user_var_q[idx]))
    else $error("accumulator not loaded from variable");

  a_bad_idx: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (ce_in && cmd_valid && !idx_ok && cmd.opcode == `IVC_OP_GET_IDX && !acc_load_in)
    |=> $stable(acc_q))
    else $error("out-of-range index changed accumulator");

  a_set_idx: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (ce_in && cmd_valid && idx_ok && cmd.opcode == `IVC_OP_SET_IDX)
    |=> user_var_q[$past(idx)] == $past(cmd.value))
    else $error("value not stored in variable");

  a_acc_idx: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (ce_in && cmd_valid && idx_ok && cmd.opcode == `IVC_OP_ACC_IDX)
    |=> user_var_q[$past(idx)] == $past(acc_q))
    else $error("accumulator not stored in variable");

  // A low enable must hold the accumulator, sequence state and reply valid where they stand.
  a_ce_freeze: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !ce_in |=> $stable(acc_q) && $stable(state_q) && $stable(reply_valid_out))
    else $error("state changed while clock enable low");

  a_reply_ok: assert property (@(posedge clock_in) disable iff (!rstn_in)
    reply_valid_out |-> reply_out.status == `IVC_STATUS_OK)
    else $error("reply status not OK");

  a_reply_sent: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (ce_in && host_valid && (host_cmd.opcode == `IVC_OP_ROT_POS ||
    host_cmd.opcode == `IVC_OP_SET_IDX || host_cmd.opcode == `IVC_OP_GET_IDX ||
    host_cmd.opcode == `IVC_OP_ACC_IDX)) |=> reply_valid_out &&
    reply_out.opcode == $past(host_cmd.opcode))
    else $error("host command got no matching reply");

  // Program commands have nobody to answer to, so no reply may follow them.
  a_prog_silent: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (ce_in && !host_valid) |=> !reply_valid_out)
    else $error("reply without a host frame");

  a_bad_no_reply: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (ce_in && frame_bad_out) |=> !reply_valid_out)
    else $error("corrupt frame was answered");
endmodule

// ===== design/ivc_consts.svh
// Constants for the indexed variable and velocity command block.
`ifndef IVC_CONSTS_SVH
`define IVC_CONSTS_SVH
`define IVC_OP_ROT_POS 8'h33
`define IVC_OP_SET_IDX 8'h37
`define IVC_OP_GET_IDX 8'h38
`define IVC_OP_ACC_IDX 8'h39
`define IVC_STATUS_OK 8'h64
`define IVC_PARAM_TGT_VEL 8'h02
// Parameter slot used to signal the velocity-mode selection step.
`define IVC_PARAM_MODE_SEL 8'h00
`define IVC_FRAME_LEN 4'h9
`define IVC_SUM_LEN 4'h8
`define IVC_IDX_MAX 32'h000000ff
`define IVC_VAR_DEPTH 256
`define IVC_ACC_RESET 32'h00000000
`endif

// ===== design/ivc_pkg.sv
// Types shared by the indexed variable and velocity command block.
package ivc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] opcode;
    logic [7:0] kind;
    logic [7:0] bank;
    logic [31:0] value;
  } ivc_cmd_s;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] opcode;
    logic [31:0] value;
  } ivc_reply_s;
  typedef struct packed {
    logic vel_mode;
    logic [7:0] param;
    logic [31:0] value;
  } ivc_axis_s;
endpackage

// ===== design/ivc_frame_rx.sv
// Nine-byte command frame assembler with checksum test.
`timescale 1ns/100ps
`include "ivc_consts.svh"
module ivc_frame_rx (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  output logic frame_valid_out,
  output logic frame_bad_out,
  output ivc_pkg::ivc_cmd_s frame_out
);
  logic [3:0] cnt_q;
  logic [7:0] sum_q;
  logic [63:0] shift_q;

  // Bytes arrive most significant first; the ninth byte is the checksum.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 4'h0;
      sum_q <= 8'h00;
      shift_q <= 64'h0;
      frame_valid_out <= 1'b0;
      frame_bad_out <= 1'b0;
      frame_out <= '0;
    end else if (ce_in) begin
      frame_valid_out <= 1'b0;
      frame_bad_out <= 1'b0;
      if (byte_valid_in) begin
        if (cnt_q == `IVC_SUM_LEN) begin
          cnt_q <= 4'h0;
          sum_q <= 8'h00;
          frame_out <= shift_q;
          frame_valid_out <= (byte_in == sum_q);
          frame_bad_out <= (byte_in != sum_q);
        end else begin
          cnt_q <= cnt_q + 4'h1;
          sum_q <= sum_q + byte_in;
          shift_q <= {shift_q[55:0], byte_in};
        end
      end
    end
  end

  a_frame_count: assert property (@(posedge clock_in) disable iff (!rstn_in)
    cnt_q < `IVC_FRAME_LEN)
    else $error("frame byte count out of range");
endmodule

// ===== dv/ivc_host_model.sv
// Host model that sends nine-byte command frames.
`timescale 1ns/100ps
module ivc_host_model (
  input wire logic clock_in,
  output logic byte_valid_out,
  output logic [7:0] byte_out
);
  initial begin
    byte_valid_out = 1'b0;
    byte_out = 8'h00;
  end
  // A corrupt sum is sent only when a test asks for it.
  task automatic send(input logic [7:0] op, input logic [31:0] v, input logic [7:0] kb,
                      input logic bad);
    logic [7:0] f [9];
    logic [7:0] sum;
    f = '{8'h01, op, kb, kb, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    sum = 8'h00;
    for (int i = 0; i < 8; i++) sum = sum + f[i];
    f[8] = sum + {7'h00, bad};
    for (int i = 0; i < 9; i++) begin
      @(posedge clock_in);
      #1;
      byte_valid_out = 1'b1;
      byte_out = f[i];
    end
    @(posedge clock_in);
    #1;
    byte_valid_out = 1'b0;
    // An idle line shows no stale byte.
    byte_out = ~f[8];
  endtask
endmodule

// ===== dv/tb_ivc_cmd_exec.sv
// Self-checking testbench for the command execution block.
`timescale 1ns/100ps
module tb_ivc_cmd_exec;
  logic clk, rstn, ce, bv, pv, ld_en, rv, awr, fbad;
  logic [7:0] bd;
  logic [31:0] x, ld_v, acc;
  ivc_pkg::ivc_cmd_s pc;
  ivc_pkg::ivc_reply_s rep;
  ivc_pkg::ivc_axis_s axis;
  int err_total = 0;
  int num_checks = 0;
  ivc_host_model host_m (.clock_in(clk), .byte_valid_out(bv), .byte_out(bd));
  ivc_cmd_exec uut (.clock_in(clk), .rstn_in(rstn), .ce_in(ce), .byte_valid_in(bv),
    .byte_in(bd), .prog_valid_in(pv), .prog_cmd_in(pc), .x_reg_in(x), .acc_load_in(ld_en),
    .acc_load_val_in(ld_v), .acc_out(acc), .reply_valid_out(rv), .reply_out(rep),
    .axis_wr_out(awr), .axis_out(axis), .frame_bad_out(fbad));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic host(input logic [7:0] op, input logic [31:0] v);
    host_m.send(op, v, 8'h00, 1'b0);
    for (int i = 0; i < 6 && rv !== 1'b1; i++) tick(1);
    chk({rv, rep.status, rep.opcode}, {1'b1, 8'h64, op});
    tick(1);
  endtask
  task automatic prog(input logic [7:0] op, input logic [31:0] v);
    pv = 1'b1;
    pc = {8'h01, op, 16'h0000, v};
    tick(1);
    pv = 1'b0;
    tick(2);
  endtask
  // Sends one frame while sampling the failure and reply pulses as they stand.
  task automatic watch(input logic [7:0] op, input logic [31:0] v, input logic bad,
                       output logic sb, output logic sr);
    sb = 1'b0;
    sr = 1'b0;
    fork
      host_m.send(op, v, 8'h00, bad);
      for (int i = 0; i < 14; i++) begin
        tick(1);
        sb = sb | (fbad === 1'b1);
        sr = sr | (rv === 1'b1);
      end
    join
  endtask
  task automatic ld(input logic [31:0] v);
    ld_en = 1'b1;
    ld_v = v;
    tick(1);
    ld_en = 1'b0;
    tick(1);
  endtask
  task automatic t_set_get;
    x = 32'h00000005;
    host(8'h37, 32'h12345678);
    ld(32'h00000000);
    prog(8'h38, 32'h00000000);
    chk(acc, 32'h12345678);
    $display("t_set_get done");
  endtask
  task automatic t_acc_idx;
    ld(32'hcafe0001);
    x = 32'h000000c8;
    host(8'h39, 32'h00000000);
    ld(32'h00000000);
    host(8'h38, 32'h00000000);
    chk(acc, 32'hcafe0001);
    $display("t_acc_idx done");
  endtask
  task automatic t_range;
    logic [31:0] xs [4] = '{32'h0, 32'h100, 32'hff, 32'hffffffff};
    for (int i = 0; i < 4; i++) begin
      x = xs[i];
      prog(8'h37, 32'ha1 + i);
    end
    x = 32'h0;
    prog(8'h38, 32'h0);
    chk(acc, 32'ha1);
    x = 32'hff;
    prog(8'h38, 32'h0);
    chk(acc, 32'ha3);
    x = 32'hffffffff;
    ld(32'h00000077);
    host(8'h38, 32'h0);
    chk(acc, 32'h77);
    $display("t_range done");
  endtask
  task automatic t_rotate;
    ld(32'h00001f40);
    // Junk in type, bank and value must not reach the axis.
    host_m.send(8'h33, 32'hffffffff, 8'ha5, 1'b0);
    for (int i = 0; i < 3 && rv !== 1'b1; i++) tick(1);
    chk({rv, rep.status, rep.opcode}, {1'b1, 8'h64, 8'h33});
    for (int i = 0; i < 8 && awr !== 1'b1; i++) tick(1);
    chk({awr, axis.vel_mode, axis.param}, {2'b11, 8'h00});
    tick(1);
    chk({awr, axis.param, axis.value}, {1'b1, 8'h02, 32'h1f40});
    tick(4);
    $display("t_rotate done");
  endtask
  task automatic t_bad_sum;
    logic sb, sr;
    x = 32'h000000ff;
    watch(8'h37, 32'h5555aaaa, 1'b1, sb, sr);
    chk({sb, sr}, {1'b1, 1'b0});
    prog(8'h38, 32'h0);
    chk(acc, 32'ha3);
    watch(8'h32, 32'h0, 1'b0, sb, sr);
    chk({sb, sr}, {1'b0, 1'b0});
    $display("t_bad_sum done");
  endtask
  task automatic t_freeze;
    x = 32'h0;
    ld(32'h0000abcd);
    ce = 1'b0;
    pv = 1'b1;
    pc = {8'h01, 8'h38, 16'h0000, 32'h0};
    tick(2);
    pv = 1'b0;
    ce = 1'b1;
    tick(1);
    chk(acc, 32'h0000abcd);
    $display("t_freeze done");
  endtask
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    pv = 1'b0;
    pc = '0;
    x = 32'h0;
    ld_en = 1'b0;
    ld_v = 32'h0;
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_set_get();
    t_acc_idx();
    t_range();
    t_rotate();
    t_bad_sum();
    t_freeze();
    final_report();
  end
  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    final_report();
  end
endmodule
